// ===== hw/fcac_top.sv
/*
 * Flash command access control: decodes writes to the command area into
 * program/erase operations, tracks suspend/resume, holds the sticky window
 * protect bit and checks the wait setting. Assumes one clock, sync reset.
 */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - writes to the fixed command area address are decoded as flash commands.
// - nine commands accepted: program, erases, suspend, resume, clear, end, blank, config.
// - option memory is changed only by the configuration setting command.
// - protect bit once cleared to 0 ignores every later write of 1.
// - commands are accepted from reset with no firmware loading step.
module fcac_top (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// command write port
	input  wire fcac_pkg::fcac_wr_t   cmd_wr,
	// protect bit write
	input  wire logic                 prot_wr,
	input  wire logic                 prot_wdata,
	// wait configuration
	input  wire logic [1:0]           flash_wait_cfg,
	input  wire logic [7:0]           core_freq_mhz,
	// status
	output var  fcac_pkg::fcac_stat_t stat,
	output var  logic                 window_protect_bit,
	output var  logic                 opt_mem_wr,
	output var  logic                 wait_bad
);
	import fcac_pkg::*;
	// ==========================================================
	// state
	typedef struct packed {
		fcac_state_t st;
		logic [15:0] remain;
		fcac_stat_t  stat;
		logic        prot;
		logic        opt_wr;
		logic        is_cfg;
	} fcac_core_t;
	fcac_core_t core_reg;
	fcac_core_t core_next;
	logic       hit;
	logic       op_start;
	assign hit = cmd_wr.valid && (cmd_wr.addr == FCAC_CMD_AREA_ADDR);
	assign op_start = (cmd_wr.data == FCAC_OP_PROGRAM) || (cmd_wr.data == FCAC_OP_BLK_ERASE)
		|| (cmd_wr.data == FCAC_OP_MULTI_ERASE) || (cmd_wr.data == FCAC_OP_BLANK_CHK)
		|| (cmd_wr.data == FCAC_OP_CONFIG_SET);
	// ==========================================================
	// next state
	always_comb begin
		core_next = core_reg;
		core_next.opt_wr = 1'b0;
		if (prot_wr && (core_reg.prot || !prot_wdata)) begin
			core_next.prot = prot_wdata;
		end
		case (core_reg.st)
			FCAC_IDLE, FCAC_DONE: begin
				if (hit && op_start) begin
					core_next.st = FCAC_BUSY;
					core_next.remain = FCAC_OP_CYCLES;
					core_next.is_cfg = (cmd_wr.data == FCAC_OP_CONFIG_SET);
					core_next.stat.done = 1'b0;
				end else if (hit && (cmd_wr.data == FCAC_OP_STAT_CLR)) begin
					core_next.stat.cmd_err = 1'b0;
					core_next.stat.done = 1'b0;
				end else if (hit && (cmd_wr.data != FCAC_OP_FORCE_END)) begin
					core_next.stat.cmd_err = 1'b1;
				end
			end
			FCAC_BUSY: begin
				if (hit && (cmd_wr.data == FCAC_OP_SUSPEND)) begin
					core_next.st = FCAC_SUSP;
				end else if (hit && (cmd_wr.data == FCAC_OP_FORCE_END)) begin
					core_next.st = FCAC_IDLE;
					core_next.remain = FCAC_CNT_ZERO;
				end else begin
					if (hit) begin
						core_next.stat.cmd_err = 1'b1;
					end
					if (core_reg.remain == FCAC_CNT_ONE) begin
						core_next.st = FCAC_DONE;
						core_next.stat.done = 1'b1;
						core_next.opt_wr = core_reg.is_cfg;
					end
					core_next.remain = core_reg.remain - FCAC_CNT_ONE;
				end
			end
			FCAC_SUSP: begin
				if (hit && (cmd_wr.data == FCAC_OP_RESUME)) begin
					core_next.st = FCAC_BUSY;
				end else if (hit && (cmd_wr.data == FCAC_OP_FORCE_END)) begin
					core_next.st = FCAC_IDLE;
					core_next.remain = FCAC_CNT_ZERO;
				end else if (hit) begin
					core_next.stat.cmd_err = 1'b1;
				end
			end
			default: begin
				core_next.st = FCAC_IDLE;
			end
		endcase
		core_next.stat.busy = (core_next.st == FCAC_BUSY);
		core_next.stat.suspended = (core_next.st == FCAC_SUSP);
	end
	// ==========================================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_reg.st <= FCAC_IDLE;
			core_reg.remain <= FCAC_CNT_ZERO;
			core_reg.stat <= '0;
			core_reg.prot <= 1'b1;
			core_reg.opt_wr <= 1'b0;
			core_reg.is_cfg <= 1'b0;
		end else begin
			core_reg <= core_next;
		end
	end
	always_comb begin
		stat = core_reg.stat;
		window_protect_bit = core_reg.prot;
		opt_mem_wr = core_reg.opt_wr;
	end
	fcac_wait_check u_wait (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.flash_wait_cfg (flash_wait_cfg),
		.core_freq_mhz  (core_freq_mhz),
		.wait_bad       (wait_bad)
	);
	// ==========================================================
	// checks
	sequence s_busy_hit;
		core_reg.st == FCAC_BUSY && hit && cmd_wr.data == FCAC_OP_SUSPEND;
	endsequence
	property p_suspend_holds;
		@(posedge ref_clk) disable iff (rst)
		s_busy_hit |=> stat.suspended && $stable(core_reg.remain);
	endproperty
	a_suspend_holds: assert property (p_suspend_holds) else $error("suspend lost");
	property p_resume_keeps;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st == FCAC_SUSP && hit && cmd_wr.data == FCAC_OP_RESUME)
			|=> stat.busy && core_reg.remain == $past(core_reg.remain);
	endproperty
	a_resume_keeps: assert property (p_resume_keeps) else $error("resume restarted");
	property p_prot_sticky;
		@(posedge ref_clk) disable iff (rst)
		!window_protect_bit |=> !window_protect_bit;
	endproperty
	a_prot_sticky: assert property (p_prot_sticky) else $error("protect bit came back");
	property p_prot_clear;
		@(posedge ref_clk) disable iff (rst)
		prot_wr && !prot_wdata |=> !window_protect_bit;
	endproperty
	a_prot_clear: assert property (p_prot_clear) else $error("protect clear ignored");
	sequence s_start;
		(core_reg.st == FCAC_IDLE || core_reg.st == FCAC_DONE) && hit && op_start;
	endsequence
	sequence s_abort_hit;
		hit && (cmd_wr.data == FCAC_OP_SUSPEND || cmd_wr.data == FCAC_OP_FORCE_END);
	endsequence
	// a suspend or forced end inside the run legally holds back done
	property p_start;
		@(posedge ref_clk) disable iff (rst)
		s_start |=> (stat.busy ##64 stat.done) or (##[0:63] s_abort_hit);
	endproperty
	a_start: assert property (p_start) else $error("operation timing wrong");
	property p_bad_cmd;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st == FCAC_IDLE && hit && !op_start && cmd_wr.data != FCAC_OP_STAT_CLR
			&& cmd_wr.data != FCAC_OP_FORCE_END) |=> stat.cmd_err;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command accepted");
	property p_opt_cfg;
		@(posedge ref_clk) disable iff (rst)
		opt_mem_wr |-> $past(core_reg.is_cfg) && stat.done;
	endproperty
	a_opt_cfg: assert property (p_opt_cfg) else $error("option write by non-config");
	property p_off_area;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st == FCAC_IDLE && !hit && !prot_wr) |=> $stable(core_reg.st);
	endproperty
	a_off_area: assert property (p_off_area) else $error("write outside area decoded");
	property p_wait;
		@(posedge ref_clk) disable iff (rst)
		(core_freq_mhz > FCAC_FREQ_MID_MHZ && core_freq_mhz <= FCAC_FREQ_MAX_MHZ
			&& flash_wait_cfg == 2'h1) |=> wait_bad;
	endproperty
	a_wait: assert property (p_wait) else $error("wait check missed");
	sequence s_force_hit;
		(core_reg.st == FCAC_BUSY || core_reg.st == FCAC_SUSP) && hit
			&& cmd_wr.data == FCAC_OP_FORCE_END;
	endsequence
	property p_force_end;
		@(posedge ref_clk) disable iff (rst)
		s_force_hit |=> !stat.busy && !stat.suspended && core_reg.remain == FCAC_CNT_ZERO;
	endproperty
	a_force_end: assert property (p_force_end) else $error("forced end ignored");
	// a second start while busy is refused but must not disturb the running one
	property p_busy_refuse;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st == FCAC_BUSY && core_reg.remain != FCAC_CNT_ONE && hit && op_start)
			|=> stat.cmd_err && stat.busy;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("start while busy taken");
	property p_susp_refuse;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st == FCAC_SUSP && hit && cmd_wr.data != FCAC_OP_RESUME
			&& cmd_wr.data != FCAC_OP_FORCE_END) |=> stat.cmd_err && stat.suspended;
	endproperty
	a_susp_refuse: assert property (p_susp_refuse) else $error("suspend left by bad code");
	property p_stat_clr;
		@(posedge ref_clk) disable iff (rst)
		(core_reg.st != FCAC_BUSY && core_reg.st != FCAC_SUSP && hit
			&& cmd_wr.data == FCAC_OP_STAT_CLR) |=> !stat.cmd_err && !stat.done;
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status clear ignored");
endmodule : fcac_top
`default_nettype wire

// ===== common/fcac_pkg.sv
/*
 * Package for the flash command access control block: command codes, state
 * encodings, wait-state limits and the command port carrier struct.
 * Assumes one 125 MHz clock; codes for commands are local choices.
 */
`default_nettype none
package fcac_pkg;
	// ==========================================================
	// command area and command codes
	localparam logic [31:0] FCAC_CMD_AREA_ADDR = 32'h007E0000;
	localparam logic [7:0]  FCAC_OP_PROGRAM    = 8'hE8;
	localparam logic [7:0]  FCAC_OP_BLK_ERASE  = 8'h20;
	localparam logic [7:0]  FCAC_OP_MULTI_ERASE = 8'h21;
	localparam logic [7:0]  FCAC_OP_SUSPEND    = 8'hB0;
	localparam logic [7:0]  FCAC_OP_RESUME     = 8'hD0;
	localparam logic [7:0]  FCAC_OP_STAT_CLR   = 8'h50;
	localparam logic [7:0]  FCAC_OP_FORCE_END  = 8'hB3;
	localparam logic [7:0]  FCAC_OP_BLANK_CHK  = 8'h71;
	localparam logic [7:0]  FCAC_OP_CONFIG_SET = 8'h40;
	// ==========================================================
	// wait states versus core clock
	localparam logic [7:0]  FCAC_FREQ_LOW_MHZ  = 8'h32;
	localparam logic [7:0]  FCAC_FREQ_MID_MHZ  = 8'h64;
	localparam logic [7:0]  FCAC_FREQ_MAX_MHZ  = 8'hC8;
	localparam logic [1:0]  FCAC_WAIT_MAX      = 2'h2;
	localparam logic [1:0]  FCAC_WAIT_RESET    = 2'h2;
	// ==========================================================
	// operation timing: busy cycles for one program or erase
	localparam logic [15:0] FCAC_OP_CYCLES     = 16'h0040;
	localparam logic [15:0] FCAC_CNT_ONE       = 16'h0001;
	localparam logic [15:0] FCAC_CNT_ZERO      = 16'h0000;
	// ==========================================================
	// states, one-hot
	typedef enum logic [3:0] {
		FCAC_IDLE    = 4'h1,
		FCAC_BUSY    = 4'h2,
		FCAC_SUSP    = 4'h4,
		FCAC_DONE    = 4'h8
	} fcac_state_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [7:0]  data;
	} fcac_wr_t;
	typedef struct packed {
		logic busy;
		logic suspended;
		logic cmd_err;
		logic done;
	} fcac_stat_t;
endpackage : fcac_pkg
`default_nettype wire

// ===== hw/fcac_wait_check.sv
/*
 * Wait-state checker: flags a read wait setting too small for the stated
 * core clock frequency. Inputs come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module fcac_wait_check (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// setting and frequency
	input  wire logic [1:0] flash_wait_cfg,
	input  wire logic [7:0] core_freq_mhz,
	// result
	output var  logic       wait_bad
);
	import fcac_pkg::*;
	logic [1:0] need;
	always_comb begin
		if (core_freq_mhz <= FCAC_FREQ_LOW_MHZ) begin
			need = 2'h0;
		end else if (core_freq_mhz <= FCAC_FREQ_MID_MHZ) begin
			need = 2'h1;
		end else begin
			need = FCAC_WAIT_MAX;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wait_bad <= 1'b0;
		end else begin
			wait_bad <= (flash_wait_cfg < need) || (flash_wait_cfg > FCAC_WAIT_MAX)
				|| (core_freq_mhz > FCAC_FREQ_MAX_MHZ);
		end
	end
endmodule : fcac_wait_check
`default_nettype wire

// ===== tb/fcac_top_tb.sv
/* Self-checking bench for fcac_top: commands, suspend, protect bit, wait check.
   Assumes fcac_pkg codes, a 64-cycle operation and a 125 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module flash_command_access_control_tb;
	import fcac_pkg::*;
	logic       ref_clk, rst, prot_wr, prot_wdata, window_protect_bit, opt_mem_wr;
	logic       wait_bad, bad;
	logic [1:0] flash_wait_cfg;
	logic [7:0] core_freq_mhz;
	fcac_wr_t   cmd_wr;
	fcac_stat_t stat, last_stat, q[$];
	int         failures, n_compared, cycles, busy_cnt, last_busy, n_opt;
	logic [7:0] codes[7] = '{8'hD0, 8'h50, 8'hFF, 8'h50, 8'hB3, 8'hB0, 8'h50};
	logic [3:0] exps[7]  = '{4'h3, 4'h0, 4'h2, 4'h0, 4'hF, 4'h2, 4'h0};
	logic [7:0] freqs[6] = '{8'h32, 8'h33, 8'h64, 8'h65, 8'hC8, 8'hC9};
	fcac_top dut_u (.ref_clk(ref_clk), .rst(rst), .cmd_wr(cmd_wr), .prot_wr(prot_wr),
		.prot_wdata(prot_wdata), .flash_wait_cfg(flash_wait_cfg),
		.core_freq_mhz(core_freq_mhz), .stat(stat), .window_protect_bit(window_protect_bit),
		.opt_mem_wr(opt_mem_wr), .wait_bad(wait_bad));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// checking
	task automatic fail(input string m);
		failures++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask : fail
	task automatic check_stat(input fcac_stat_t e);
		n_compared++;
		if (stat !== e) fail($sformatf("stat %h expected %h", stat, e));
	endtask : check_stat
	task automatic check_bit(input logic g, input logic e, input string m);
		n_compared++;
		if (g !== e) fail(m);
	endtask : check_bit
	task automatic finish_test();
		if (q.size() != 0) fail("status changes missing");
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// ==========================================================
	// driving
	task automatic note(input logic [3:0] e);
		q.push_back(fcac_stat_t'(e));
	endtask : note
	task automatic cmd(input logic [31:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		cmd_wr = '{1'b1, a, d};
		@(negedge ref_clk);
		cmd_wr.valid = 1'b0;
	endtask : cmd
	// bounded wait for the noted status changes to appear
	task automatic drain(input int lim);
		for (int i = 0; i < lim && q.size() > 0; i++) @(negedge ref_clk);
	endtask : drain
	task automatic prot(input logic v, input logic e);
		@(negedge ref_clk);
		prot_wr = 1'b1;
		prot_wdata = v;
		@(negedge ref_clk);
		prot_wr = 1'b0;
		@(negedge ref_clk);
		check_bit(window_protect_bit, e, "protect bit");
	endtask : prot
	// ==========================================================
	// monitor: every status change consumes the oldest note
	always @(posedge ref_clk) begin
		#1;
		cycles++;
		if (!rst) begin
			if (opt_mem_wr === 1'b1) n_opt++;
			// a resume keeps the count, so only a fresh start clears it
			if (stat.busy === 1'b1 && last_stat.busy !== 1'b1 && last_stat.suspended !== 1'b1)
				busy_cnt = 0;
			if (stat.busy === 1'b1) busy_cnt++;
			if (stat.done === 1'b1 && last_stat.done !== 1'b1) last_busy = busy_cnt;
			if (stat !== last_stat) begin
				if (q.size() == 0) fail("unexpected status change");
				else check_stat(q.pop_front());
			end
			last_stat = stat;
		end
		if (cycles == 4000) begin
			fail("timeout");
			finish_test();
		end
	end
	initial begin
		rst = 1'b1;
		cmd_wr = '0;
		prot_wr = 1'b0;
		prot_wdata = 1'b0;
		flash_wait_cfg = 2'h2;
		core_freq_mhz = 8'h64;
		last_stat = '0;
		void'($urandom(85903));
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		check_bit(window_protect_bit, 1'b1, "protect reset");
		note(4'h8);
		note(4'h1);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_PROGRAM);
		drain(80);
		check_bit(last_busy == 64, 1'b1, "operation length");
		check_bit(n_opt == 0, 1'b1, "option write by program");
		note(4'h8);
		note(4'h1);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_CONFIG_SET);
		drain(80);
		repeat (2) @(negedge ref_clk);
		check_bit(n_opt == 1, 1'b1, "option write by config");
		note(4'h8);
		note(4'h4);
		note(4'h8);
		note(4'h1);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_BLK_ERASE);
		repeat (10) @(negedge ref_clk);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_SUSPEND);
		repeat (100) @(negedge ref_clk);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_RESUME);
		drain(80);
		check_bit(last_busy inside {[62:66]}, 1'b1, "resume restarted");
		repeat (3) cmd($urandom() | 32'h1, FCAC_OP_PROGRAM);
		for (int i = 0; i < 7; i++) begin
			if (exps[i] != 4'hF) note(exps[i]);
			cmd(FCAC_CMD_AREA_ADDR, codes[i]);
			drain(10);
		end
		note(4'h8);
		note(4'hA);
		note(4'h3);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_MULTI_ERASE);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_PROGRAM);
		drain(80);
		note(4'h0);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_STAT_CLR);
		note(4'h8);
		note(4'h0);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_BLANK_CHK);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_FORCE_END);
		note(4'h8);
		note(4'h4);
		note(4'h6);
		note(4'h2);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_BLK_ERASE);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_SUSPEND);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_PROGRAM);
		cmd(FCAC_CMD_AREA_ADDR, FCAC_OP_FORCE_END);
		drain(10);
		prot(1'b1, 1'b1);
		prot(1'b0, 1'b0);
		prot(1'b1, 1'b0);
		for (int i = 0; i < 26; i++) begin
			@(negedge ref_clk);
			flash_wait_cfg = (i < 6) ? 2'(i % 3) : 2'($urandom_range(3));
			core_freq_mhz = (i < 6) ? freqs[i] : 8'($urandom_range(255));
			bad = flash_wait_cfg > 2 || core_freq_mhz > 200 ||
				(core_freq_mhz > 100 && flash_wait_cfg < 2) ||
				(core_freq_mhz > 50 && flash_wait_cfg < 1);
			repeat (2) @(negedge ref_clk);
			check_bit(wait_bad, bad, "wait setting check");
		end
		finish_test();
	end
endmodule : flash_command_access_control_tb
`default_nettype wire
